// ===== rtl/vtc_pkg.sv
// Constants shared by the vendor RF test command decoder
package vtc_pkg;
    // Register byte offsets
    localparam logic [7:0] VTC_OFS_OPCODE = 8'h00;
    localparam logic [7:0] VTC_OFS_ARGS = 8'h04;
    localparam logic [7:0] VTC_OFS_ISSUE = 8'h08;
    localparam logic [7:0] VTC_OFS_RESULT = 8'h0C;
    localparam logic [7:0] VTC_OFS_RF_INIT = 8'h10;
    localparam logic [7:0] VTC_OFS_CALIB = 8'h14;
    localparam logic [7:0] VTC_OFS_IDLE = 8'h18;
    localparam logic [7:0] VTC_OFS_TEST = 8'h1C;
    localparam logic [7:0] VTC_OFS_HW_ERROR = 8'h20;
    // Field positions
    localparam int VTC_RESULT_DONE_BIT = 31;
    localparam int VTC_TEST_ACTIVE_BIT = 31;
    // Opcodes
    localparam logic [15:0] VTC_OP_RF_INIT = 16'hFC0D;
    localparam logic [15:0] VTC_OP_READ_CAL = 16'hFC0E;
    localparam logic [15:0] VTC_OP_WRITE_CAL = 16'hFC0F;
    localparam logic [15:0] VTC_OP_IDLE = 16'hFC10;
    localparam logic [15:0] VTC_OP_TX_START = 16'hFC11;
    localparam logic [15:0] VTC_OP_TX_STOP = 16'hFC12;
    // Status codes
    localparam logic [7:0] VTC_ST_OK = 8'h00;
    localparam logic [7:0] VTC_ST_UNKNOWN = 8'h01;
    localparam logic [7:0] VTC_ST_DISALLOWED = 8'h0C;
    localparam logic [7:0] VTC_ST_BAD_PARAM = 8'h12;
    // Hardware error code for failed initialization
    localparam logic [7:0] VTC_HWERR_RF_INIT = 8'h02;
    // Parameter limits (first reserved code, or inclusive bound for MAX and MIN names) and base frequency
    localparam logic [7:0] VTC_INIT_MODE_RSVD = 8'h03;
    localparam logic [7:0] VTC_ITER_RSVD = 8'h04;
    localparam logic [7:0] VTC_VCO_MAX = 8'h0F;
    localparam logic [7:0] VTC_MOD_MAX = 8'h3F;
    localparam logic [7:0] VTC_SCA_RSVD = 8'h06;
    localparam logic [15:0] VTC_IDLE_MIN_MS = 16'd15;
    localparam logic [15:0] VTC_IDLE_MAX_MS = 16'd10240;
    localparam logic [7:0] VTC_TMODE_RSVD = 8'h05;
    localparam logic [7:0] VTC_CHAN_RSVD = 8'h28;
    localparam logic [7:0] VTC_LEN_RSVD = 8'h26;
    localparam logic [7:0] VTC_PAYLOAD_RSVD = 8'h08;
    localparam logic [11:0] VTC_BASE_MHZ = 12'd2402;
    // Reset values
    localparam logic [1:0] VTC_RST_ITER = 2'h2;
    localparam logic [3:0] VTC_RST_VCO = 4'h0;
    localparam logic [5:0] VTC_RST_MOD = 6'h00;
    localparam logic [2:0] VTC_RST_SCA = 3'h0;
    localparam logic [15:0] VTC_RST_IDLE_MS = 16'd25;
    localparam logic [3:0] VTC_RST_MASK = 4'hF;
    // Test modes
    typedef enum logic [2:0] {
        VTC_TM_COUNTED = 3'b000,
        VTC_TM_MODULATED = 3'b001,
        VTC_TM_CW_ZERO = 3'b010,
        VTC_TM_CW_ONE = 3'b011,
        VTC_TM_CW_CENTRE = 3'b100
    } vtc_test_mode_t;
endpackage : vtc_pkg

// ===== rtl/vtc_decoder.sv
// Vendor RF test command decoder with AHB-Lite register access
//
// The AHB-Lite slave port and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Init mode byte: 0 disable, 1 enable per operation, 2 one-shot now.
// - Iteration byte 0..3 gives 1, 2, 4, 8 passes; higher reserved.
// - Read-calibration returns status, oscillator trim, modulator calibration.
// - Write-calibration oscillator trim must be 0..0x0F; applied to oscillator.
// - Modulator calibration must be 0..0x3F; drives modulator.
// - Idle parameters accepted only without radio activity.
// - Sleep clock accuracy bands 0..5; 6 and above reserved.
// - Minimum idle length valid 15..10240 ms, default 25.
// - Idle role mask bits 0..3 per role; bits 4..7 reserved; default 0x0F.
// - Test start accepted only without radio activity.
// - Test mode 0..4: counted, modulated, three carrier tests; higher reserved.
// - Channel 0..0x27, frequency 2402 plus twice channel MHz.
// - Payload length 0..0x25 bytes per packet in counted/modulated modes.
// - Payload type 0..7 decoded to PRBS9 or fixed patterns.
// - Length and payload always range-checked, used only in counted/modulated.
// - Tests transmit at power level chosen by the power command.
// - Test stop accepted only without radio activity; ends running test.
// - Every command returns a one-byte standard status.
// - Stop response carries two-byte sent packet count.
// - Failed initialization raises hardware error with code 0x02.
module vtc_decoder
    import vtc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic radio_activity,
    input wire logic [2:0] output_power_level,
    input wire logic rf_init_fail,
    input wire logic packet_sent,
    output logic rf_init_each_op,
    output logic [1:0] rf_init_iteration_byte,
    output logic rf_init_start,
    output logic [3:0] oscillator_trim_value,
    output logic [5:0] modulator_trim_value,
    output logic [2:0] sleep_clock_accuracy_band,
    output logic [15:0] minimum_idle_length_ms,
    output logic [3:0] idle_role_mask,
    output logic tx_test_active,
    output vtc_test_mode_t tx_test_mode,
    output logic [11:0] tx_freq_mhz,
    output logic [5:0] test_payload_length,
    output logic [2:0] tx_payload_type,
    output logic [2:0] tx_power_level,
    output logic [15:0] sent_packet_count,
    output logic hw_error_event,
    output logic [7:0] hw_error_code
);

    // ****************************************
    // Bus slave
    // ****************************************
    logic wr_pend;
    logic rd_pend;
    logic rd_wait;
    logic [7:0] dp_addr;
    logic addr_ok;
    logic [15:0] opcode;
    logic [31:0] args;
    logic issue;
    logic [31:0] read_mux;
    logic [7:0] res_status;
    logic [7:0] res_byte1;
    logic [7:0] res_byte2;
    logic res_done;

    assign addr_ok = hsel && hready && htrans[1];
    // Reads take one wait state so a read right after a write sees the update
    assign hreadyout = !(rd_pend && rd_wait);
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            dp_addr <= 8'h00;
        end else if (hreadyout) begin
            wr_pend <= addr_ok && hwrite;
            rd_pend <= addr_ok && !hwrite;
            dp_addr <= {haddr[7:2], 2'b00};
        end
    end

    // Toggles every cycle while a read is pending so the second data-phase cycle answers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_wait <= 1'b1;
        end else if (rd_pend) begin
            rd_wait <= !rd_wait;
        end else begin
            rd_wait <= 1'b1;
        end
    end

    // Plain storage; nothing acts until the issue write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            opcode <= 16'h0000;
            args <= 32'h0000_0000;
        end else if (wr_pend) begin
            if (dp_addr == VTC_OFS_OPCODE) begin
                opcode <= hwdata[15:0];
            end
            if (dp_addr == VTC_OFS_ARGS) begin
                args <= hwdata;
            end
        end
    end

    assign issue = wr_pend && (dp_addr == VTC_OFS_ISSUE) && hwdata[0];

    // Unmapped offsets read as zero
    always_comb begin
        case (dp_addr)
            VTC_OFS_OPCODE: read_mux = {16'h0000, opcode};
            VTC_OFS_ARGS: read_mux = args;
            VTC_OFS_RESULT: read_mux = {res_done, 7'h00, res_byte2, res_byte1, res_status};
            VTC_OFS_RF_INIT: read_mux = {29'h0000_0000, rf_init_each_op, rf_init_iteration_byte};
            VTC_OFS_CALIB: read_mux = {18'h0_0000, modulator_trim_value, 4'h0, oscillator_trim_value};
            VTC_OFS_IDLE: read_mux = {5'h00, sleep_clock_accuracy_band, minimum_idle_length_ms,
                                      4'h0, idle_role_mask};
            VTC_OFS_TEST: read_mux = {tx_test_active, 12'h000, tx_payload_type, 2'b00,
                                      test_payload_length, 5'h00, tx_test_mode};
            VTC_OFS_HW_ERROR: read_mux = {24'h00_0000, hw_error_code};
            default: read_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_pend && rd_wait) begin
            hrdata <= read_mux;
        end
    end

    // ****************************************
    // Parameter checks
    // ****************************************
    logic [7:0] arg0;
    logic [7:0] arg1;
    logic [7:0] arg2;
    logic [7:0] arg3;
    logic [15:0] idle_ms;
    logic known_op;
    logic needs_quiet;
    logic params_ok;
    logic cmd_ok;
    logic [7:0] status;

    assign arg0 = args[7:0];
    assign arg1 = args[15:8];
    assign arg2 = args[23:16];
    assign arg3 = args[31:24];
    assign idle_ms = {arg2, arg1};

    always_comb begin
        known_op = 1'b1;
        needs_quiet = 1'b0;
        params_ok = 1'b1;
        case (opcode)
            VTC_OP_RF_INIT: begin
                params_ok = (arg0 < VTC_INIT_MODE_RSVD) && (arg1 < VTC_ITER_RSVD);
            end
            VTC_OP_READ_CAL: begin
                params_ok = 1'b1;
            end
            VTC_OP_WRITE_CAL: begin
                params_ok = (arg0 <= VTC_VCO_MAX) && (arg1 <= VTC_MOD_MAX);
            end
            VTC_OP_IDLE: begin
                needs_quiet = 1'b1;
                params_ok = (arg0 < VTC_SCA_RSVD)
                    && (idle_ms >= VTC_IDLE_MIN_MS) && (idle_ms <= VTC_IDLE_MAX_MS)
                    && (arg3[7:4] == 4'h0);
            end
            VTC_OP_TX_START: begin
                needs_quiet = 1'b1;
                params_ok = (arg0 < VTC_TMODE_RSVD)
                    && (arg1 < VTC_CHAN_RSVD)
                    && (arg2 < VTC_LEN_RSVD) && (arg3 < VTC_PAYLOAD_RSVD);
            end
            VTC_OP_TX_STOP: begin
                needs_quiet = 1'b1;
            end
            default: begin
                known_op = 1'b0;
            end
        endcase
    end

    // Activity is checked before parameters so a busy radio never reports a parameter fault for idle, start or stop
    always_comb begin
        if (!known_op) begin
            status = VTC_ST_UNKNOWN;
        end else if (needs_quiet && radio_activity) begin
            status = VTC_ST_DISALLOWED;
        end else if (!params_ok) begin
            status = VTC_ST_BAD_PARAM;
        end else begin
            status = VTC_ST_OK;
        end
    end

    // Settings move only on a clean status
    assign cmd_ok = issue && (status == VTC_ST_OK);

    // ****************************************
    // Command response
    // ****************************************
    // Result bytes a command does not use read back as zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            res_status <= VTC_ST_OK;
            res_byte1 <= 8'h00;
            res_byte2 <= 8'h00;
            res_done <= 1'b0;
        end else if (issue) begin
            res_status <= status;
            res_done <= 1'b1;
            res_byte1 <= 8'h00;
            res_byte2 <= 8'h00;
            if (status == VTC_ST_OK && opcode == VTC_OP_READ_CAL) begin
                res_byte1 <= {4'h0, oscillator_trim_value};
                res_byte2 <= {2'b00, modulator_trim_value};
            end
            if (status == VTC_ST_OK && opcode == VTC_OP_TX_STOP) begin
                res_byte1 <= sent_packet_count[7:0];
                res_byte2 <= sent_packet_count[15:8];
            end
        end
    end

    // ****************************************
    // RF initialization
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rf_init_each_op <= 1'b1;
            rf_init_iteration_byte <= VTC_RST_ITER;
        end else if (cmd_ok && opcode == VTC_OP_RF_INIT) begin
            rf_init_iteration_byte <= arg1[1:0];
            if (arg0[1:0] != 2'h2) begin
                rf_init_each_op <= arg0[0];
            end
        end
    end

    // One-shot request, a single-cycle pulse towards the radio
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rf_init_start <= 1'b0;
        end else begin
            rf_init_start <= cmd_ok && opcode == VTC_OP_RF_INIT && arg0[1:0] == 2'h2;
        end
    end

    // Code holds after the pulse so software can still read the cause
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hw_error_event <= 1'b0;
            hw_error_code <= 8'h00;
        end else begin
            hw_error_event <= rf_init_fail;
            if (rf_init_fail) begin
                hw_error_code <= VTC_HWERR_RF_INIT;
            end
        end
    end

    // ****************************************
    // Calibration and idle settings
    // ****************************************
    // Ranges checked above, so only the used bits are kept
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            oscillator_trim_value <= VTC_RST_VCO;
            modulator_trim_value <= VTC_RST_MOD;
        end else if (cmd_ok && opcode == VTC_OP_WRITE_CAL) begin
            oscillator_trim_value <= arg0[3:0];
            modulator_trim_value <= arg1[5:0];
        end
    end

    // Reserved mask bits are refused, never stored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sleep_clock_accuracy_band <= VTC_RST_SCA;
            minimum_idle_length_ms <= VTC_RST_IDLE_MS;
            idle_role_mask <= VTC_RST_MASK;
        end else if (cmd_ok && opcode == VTC_OP_IDLE) begin
            sleep_clock_accuracy_band <= arg0[2:0];
            minimum_idle_length_ms <= idle_ms;
            idle_role_mask <= arg3[3:0];
        end
    end

    // ****************************************
    // Transmitter test
    // ****************************************
    logic start_ok;
    logic stop_ok;
    logic counting_mode;

    assign start_ok = cmd_ok && opcode == VTC_OP_TX_START;
    assign stop_ok = cmd_ok && opcode == VTC_OP_TX_STOP;
    assign counting_mode = (tx_test_mode == VTC_TM_COUNTED) || (tx_test_mode == VTC_TM_MODULATED);

    // A refused stop leaves the test running
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_test_active <= 1'b0;
        end else if (start_ok) begin
            tx_test_active <= 1'b1;
        end else if (stop_ok) begin
            tx_test_active <= 1'b0;
        end
    end

    // Length and payload kept in every mode; the radio uses them in two modes only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_test_mode <= VTC_TM_COUNTED;
            tx_freq_mhz <= VTC_BASE_MHZ;
            test_payload_length <= 6'h00;
            tx_payload_type <= 3'h0;
        end else if (start_ok) begin
            tx_test_mode <= vtc_test_mode_t'(arg0[2:0]);
            tx_freq_mhz <= VTC_BASE_MHZ + {5'h00, arg1[5:0], 1'b0};
            test_payload_length <= arg2[5:0];
            tx_payload_type <= arg3[2:0];
        end
    end

    // Power level tracks the separate power command while a test runs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_power_level <= 3'h0;
        end else begin
            tx_power_level <= output_power_level;
        end
    end

    // Saturates rather than wraps so a long test never reports a small count
    // Carrier tests do not count packets; their start still clears the count
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sent_packet_count <= 16'h0000;
        end else if (start_ok) begin
            sent_packet_count <= 16'h0000;
        end else if (tx_test_active && counting_mode && packet_sent && sent_packet_count != 16'hFFFF) begin
            sent_packet_count <= sent_packet_count + 16'h0001;
        end
    end

endmodule : vtc_decoder
`default_nettype wire

// ===== verification/vtc_decoder_assertions.sv
// Checker for the vendor RF test command decoder ports
`timescale 1ns/10ps
`default_nettype none
module vtc_decoder_assertions
    import vtc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic radio_activity,
    input wire logic [2:0] output_power_level,
    input wire logic rf_init_fail,
    input wire logic packet_sent,
    input wire logic rf_init_start,
    input wire logic tx_test_active,
    input wire vtc_test_mode_t tx_test_mode,
    input wire logic [11:0] tx_freq_mhz,
    input wire logic [5:0] test_payload_length,
    input wire logic [2:0] sleep_clock_accuracy_band,
    input wire logic [15:0] minimum_idle_length_ms,
    input wire logic [3:0] idle_role_mask,
    input wire logic [2:0] tx_power_level,
    input wire logic [15:0] sent_packet_count,
    input wire logic hw_error_event,
    input wire logic [7:0] hw_error_code
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence rd_req;
        hsel && hready && htrans[1] && !hwrite;
    endsequence
    sequence rd_answer;
        !hreadyout ##1 hreadyout;
    endsequence
    AST_READ_WAIT: assert property (rd_req |=> rd_answer)
        else $error("read answer not after one wait");
    AST_OKAY: assert property (hresp == 1'b0) else $error("response not okay");
    AST_INIT_PULSE: assert property (rf_init_start |=> !rf_init_start)
        else $error("init start longer than a cycle");
    AST_HW_ERROR: assert property (rf_init_fail |=> hw_error_event && hw_error_code == VTC_HWERR_RF_INIT)
        else $error("no hardware error after init failure");
    AST_HW_CAUSE: assert property (hw_error_event |-> $past(rf_init_fail))
        else $error("hardware error without cause");
    AST_POWER: assert property ($past(hresetn) |-> tx_power_level == $past(output_power_level))
        else $error("power level not followed");
    AST_FREQ: assert property (tx_freq_mhz >= VTC_BASE_MHZ && tx_freq_mhz <= 12'h9B0 && !tx_freq_mhz[0])
        else $error("frequency off grid");
    AST_MODE: assert property (tx_test_mode <= VTC_TM_CW_CENTRE)
        else $error("reserved test mode held");
    AST_LEN: assert property (test_payload_length <= 6'h25)
        else $error("reserved length held");
    AST_IDLE_RANGE: assert property (sleep_clock_accuracy_band < 3'h6 && minimum_idle_length_ms >= VTC_IDLE_MIN_MS
        && minimum_idle_length_ms <= VTC_IDLE_MAX_MS)
        else $error("idle setting out of range");
    AST_IDLE_GATE: assert property (!$stable({sleep_clock_accuracy_band, minimum_idle_length_ms, idle_role_mask})
        |-> !$past(radio_activity))
        else $error("idle changed under activity");
    AST_START_GATE: assert property ($rose(tx_test_active) |-> !$past(radio_activity))
        else $error("test started under activity");
    AST_STOP_GATE: assert property ($fell(tx_test_active) |-> !$past(radio_activity))
        else $error("test stopped under activity");
    AST_COUNT: assert property (tx_test_active && tx_test_mode == VTC_TM_COUNTED && packet_sent
        && sent_packet_count != 16'hFFFF |=> sent_packet_count == $past(sent_packet_count) + 16'h0001)
        else $error("packet not counted");
endmodule : vtc_decoder_assertions
bind vtc_decoder vtc_decoder_assertions u_vtc_decoder_assertions (.*);
`default_nettype wire

// ===== verification/vtc_radio_model.sv
// Behavioural radio standing behind the decoder
`timescale 1ns/10ps
`default_nettype none
module vtc_radio_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic rf_init_start,
    input wire logic tx_test_active,
    input wire logic fail_init,
    input wire logic send_on,
    output logic rf_init_fail,
    output logic packet_sent,
    output logic [15:0] model_count
);
    logic [1:0] gap;
    // Failure only when the bench asks for it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) rf_init_fail <= 1'b0;
        else rf_init_fail <= rf_init_start && fail_init;
    end
    // Sparse packets so each pulse stands alone
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gap <= 2'h0;
            packet_sent <= 1'b0;
            model_count <= 16'h0000;
        end else begin
            gap <= gap + 2'h1;
            packet_sent <= send_on && tx_test_active && gap == 2'h0;
            if (packet_sent) model_count <= model_count + 16'h0001;
        end
    end
endmodule : vtc_radio_model
`default_nettype wire

// ===== verification/testbench.sv
// Self-checking bench for the vendor RF test command decoder
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import vtc_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic radio_activity = 1'b0;
    logic [2:0] output_power_level = 3'h5;
    logic fail_init = 1'b0;
    logic send_on = 1'b0;
    wire logic hready;
    logic [31:0] hrdata, res, rd, a;
    logic hreadyout, hresp, rf_init_fail, packet_sent, rf_init_each_op, rf_init_start;
    logic tx_test_active, hw_error_event, ok;
    logic [1:0] rf_init_iteration_byte;
    logic [3:0] oscillator_trim_value, idle_role_mask;
    logic [5:0] modulator_trim_value, test_payload_length;
    logic [2:0] sleep_clock_accuracy_band, tx_payload_type, tx_power_level;
    logic [15:0] minimum_idle_length_ms, sent_packet_count, model_count, e_cal;
    vtc_test_mode_t tx_test_mode;
    logic [11:0] tx_freq_mhz;
    logic [7:0] hw_error_code;
    logic [2:0] e_init;
    logic [31:0] e_idle;
    int n_mismatch = 0;
    int compares = 0;
    logic [7:0] ofs [6] = '{VTC_OFS_RF_INIT, VTC_OFS_CALIB, VTC_OFS_IDLE, VTC_OFS_TEST, VTC_OFS_HW_ERROR, 8'h24};
    logic [31:0] rstv [6] = '{32'h0000_0006, 32'h0000_0000, 32'h0000_190F, 32'h0000_0000, 32'h0000_0000,
        32'h0000_0000};
    logic [15:0] initv [5] = '{16'h0001, 16'h0100, 16'h0302, 16'h0003, 16'h0401};
    logic [31:0] calv [4] = '{32'h0000_3F0F, 32'h0000_0010, 32'h0000_4000, 32'h0000_2A05};
    logic [31:0] idv [7] = '{32'h0A00_0F05, 32'h0A00_0F05, 32'h0F28_0000, 32'h0F28_0100, 32'h0F00_0E00,
        32'h0F00_1906, 32'h1F00_0F00};
    logic [31:0] stv [6] = '{32'h0725_2700, 32'h0725_2705, 32'h0725_2800, 32'h0726_2702, 32'h0825_2703,
        32'h0725_2700};
    assign hready = hreadyout;
    vtc_decoder u_vtc_decoder (.*);
    vtc_radio_model u_vtc_radio_model (.*);
    always #2 hclk = ~hclk;
    // ****
    // Bus and check tasks
    // ****
    task automatic close_out;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Sampled at the falling edge so the rising edge sees the same value
    task automatic phase(output logic [31:0] q);
        int n;
        n = 0;
        @(negedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 16) begin
                chk("hready", 32'h0000_0001, 32'h0000_0000);
                close_out();
            end
            @(negedge hclk);
        end
        q = hrdata;
        @(posedge hclk);
    endtask : phase
    task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, ad};
        htrans <= 2'h2;
        hwrite <= w;
        phase(q);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        phase(q);
    endtask : xfer
    task automatic cmd(input logic [15:0] op, input logic [31:0] args);
        xfer(1'b1, VTC_OFS_OPCODE, {16'h0000, op}, rd);
        xfer(1'b1, VTC_OFS_ARGS, args, rd);
        xfer(1'b1, VTC_OFS_ISSUE, 32'h0000_0001, rd);
        xfer(1'b0, VTC_OFS_RESULT, 32'h0000_0000, res);
    endtask : cmd
    task automatic st(input logic [7:0] e);
        chk("status", {23'h00_0000, 1'b1, e}, {23'h00_0000, res[31], res[7:0]});
    endtask : st
    // ****
    // Scenarios
    // ****
    initial begin
        e_init = 3'h6;
        e_cal = 16'h0000;
        e_idle = 32'h0000_190F;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(1'b1, 8'h24, 32'hFFFF_FFFF, rd);
        foreach (ofs[i]) begin
            xfer(1'b0, ofs[i], 32'h0000_0000, rd);
            chk("reset", rstv[i], rd);
        end
        chk("freq", 32'(VTC_BASE_MHZ), 32'(tx_freq_mhz));
        cmd(16'hFC00, 32'h0000_0000);
        st(VTC_ST_UNKNOWN);
        foreach (initv[k]) begin
            fail_init <= initv[k][7:0] == 8'h02;
            cmd(VTC_OP_RF_INIT, {16'h0000, initv[k]});
            ok = initv[k][7:0] < VTC_INIT_MODE_RSVD && initv[k][15:8] < VTC_ITER_RSVD;
            if (ok) e_init = {initv[k][7:0] == 8'h02 ? e_init[2] : initv[k][0], initv[k][9:8]};
            st(ok ? VTC_ST_OK : VTC_ST_BAD_PARAM);
            chk("init", 32'(e_init), 32'({rf_init_each_op, rf_init_iteration_byte}));
        end
        chk("hw error", 32'(VTC_HWERR_RF_INIT), 32'(hw_error_code));
        foreach (calv[k]) begin
            cmd(VTC_OP_WRITE_CAL, calv[k]);
            ok = calv[k][7:0] <= VTC_VCO_MAX && calv[k][15:8] <= VTC_MOD_MAX;
            if (ok) e_cal = calv[k][15:0];
            st(ok ? VTC_ST_OK : VTC_ST_BAD_PARAM);
            chk("cal", 32'(e_cal), 32'({2'h0, modulator_trim_value, 4'h0, oscillator_trim_value}));
            cmd(VTC_OP_READ_CAL, 32'h0000_0000);
            chk("readcal", 32'({e_cal[13:8], e_cal[3:0]}), 32'({res[21:16], res[11:8]}));
        end
        foreach (idv[k]) begin
            a = idv[k];
            radio_activity <= k == 0;
            cmd(VTC_OP_IDLE, a);
            ok = k != 0 && a[7:0] < VTC_SCA_RSVD && a[23:8] >= VTC_IDLE_MIN_MS && a[23:8] <= VTC_IDLE_MAX_MS
                && a[31:28] == 4'h0;
            st(k == 0 ? VTC_ST_DISALLOWED : ok ? VTC_ST_OK : VTC_ST_BAD_PARAM);
            if (ok) e_idle = {5'h00, a[2:0], a[23:8], 4'h0, a[27:24]};
            chk("idle", e_idle, {5'h00, sleep_clock_accuracy_band, minimum_idle_length_ms, 4'h0, idle_role_mask});
        end
        foreach (stv[k]) begin
            a = stv[k];
            radio_activity <= k == 0;
            cmd(VTC_OP_TX_START, a);
            ok = k != 0 && a[7:0] < VTC_TMODE_RSVD && a[15:8] < VTC_CHAN_RSVD && a[23:16] < VTC_LEN_RSVD
                && a[31:24] < VTC_PAYLOAD_RSVD;
            st(k == 0 ? VTC_ST_DISALLOWED : ok ? VTC_ST_OK : VTC_ST_BAD_PARAM);
            chk("active", 32'(ok), 32'(tx_test_active));
        end
        chk("test", 32'({6'h25, 3'h7, VTC_TM_COUNTED, 12'h9B0}),
            32'({test_payload_length, tx_payload_type, tx_test_mode, tx_freq_mhz}));
        send_on <= 1'b1;
        repeat (24) @(posedge hclk);
        send_on <= 1'b0;
        radio_activity <= 1'b1;
        cmd(VTC_OP_TX_STOP, 32'h0000_0000);
        st(VTC_ST_DISALLOWED);
        chk("active", 32'h0000_0001, 32'(tx_test_active));
        radio_activity <= 1'b0;
        cmd(VTC_OP_TX_STOP, 32'h0000_0000);
        st(VTC_ST_OK);
        chk("count", 32'(model_count), 32'(res[23:8]));
        chk("active", 32'h0000_0000, 32'(tx_test_active));
        for (int m = 1; m < 5; m++) begin
            output_power_level <= 3'(m);
            cmd(VTC_OP_TX_START, {16'h0000, 8'(m), 8'(m)});
            st(VTC_ST_OK);
            chk("mode", 32'({3'(m), 12'h962 + 12'(2 * m)}), 32'({tx_test_mode, tx_freq_mhz}));
            chk("power", 32'(m), 32'(tx_power_level));
        end
        send_on <= 1'b1;
        repeat (8) @(posedge hclk);
        send_on <= 1'b0;
        cmd(VTC_OP_TX_STOP, 32'h0000_0000);
        st(VTC_ST_OK);
        chk("carrier count", 32'h0000_0000, 32'(res[23:8]));
        close_out();
    end
endmodule : testbench
`default_nettype wire
